// ### rtl/aspc_top.sv
`timescale 1ns/10ps
// Function
// - Internal gain cal: amp stage one off, stage two unity, reference and ground applied.
// - System gain cal: coefficient makes selected channel read full scale, stored.
// - Non-chopping raw value enters correction at eight times 16-bit full scale.
// - Correction first subtracts stored offset coefficient from raw value.
// - Multiply by gain, divide by 65536 times 8 for 16-bit scale.
// - Overflow flag set outside -32768..+32768, cleared otherwise.
// - On overflow the result saturates to -32768 or +32767 by sign.
// - Chopping modes skip offset subtraction, use gain only.
// - Three wires only; chip select permanently asserted, no framing from it.
// - Data in sampled on falling clock, data out updated on rising.
// - All fields shift most significant bit first.
// - Command byte then one 8 or 16 bit transfer, then back.
// - Command: index bits 7-4, direction bit 3, length bit 2, zeros.
// - Status byte: zeros, pending flag in bit 1, overflow in bit 0.
// - Idle data out shows pending flag: 1 converting, 0 finished.
// - A zero then 23 ones on data in resets the device.
// - Control at index 0, first result at 1; mode 2 starts single.
// - Continuous: ready falls on store, rises after both result reads.
// - Unread result: ready rises at next conversion end, discards, falls again.
// - After gain cal: gain updated, ready falls, mode returns to idle.
module aspc_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } aspc_fifo_s;
   aspc_fifo_s s, n;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full, empty;

   // Power of two depth keeps wrap logic to a plain pointer carry
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
      $error("aspc_fifo depth must be a power of two");
   end

   // Extra pointer bit tells full from empty
   assign full = (s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]);
   assign empty = (s.wr == s.rd);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem[s.rd[AW-1:0]];

   // Pointer advance on each accepted beat
   always_comb begin
      n = s;
      if (in_valid && !full) begin
         n.wr = s.wr + 1'b1;
      end
      if (out_ready && !empty) begin
         n.rd = s.rd + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Storage has no reset; only written slots are ever read
   always_ff @(posedge clock) begin
      if (in_valid && !full) begin
         mem[s.wr[AW-1:0]] <= in_data;
      end
   end
endmodule // aspc_fifo

module aspc_top
   import aspc_pkg::*;
#(
   parameter int RAW_W = 24,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic link_din,
   output logic link_dout,
   input wire logic raw_valid,
   output logic raw_ready,
   input wire logic [RAW_W-1:0] raw_data,
   output logic [3:0] conv_mode,
   output logic [2:0] input_channel_select,
   output logic first_stage_enable,
   output logic second_stage_unity,
   output logic ref_to_input,
   output logic gnd_to_input,
   output logic conversion_pending_flag,
   output logic result_overflow_flag
);
   typedef struct packed {
      aspc_core_e st;
      logic [3:0] mode;
      logic ovf;
      logic pend;
      logic [2:0] chsel;
      logic [15:0] res;
      logic [23:0] offs;
      logic [23:0] gain;
      logic rd_first;
      logic rd_second;
      logic sck_s1;
      logic sck_s2;
      logic sck_d;
      logic din_s1;
      logic din_s2;
      logic act;
      logic in_data;
      logic [4:0] cnt;
      logic len16;
      logic [7:0] cmd;
      logic [15:0] shin;
      logic [15:0] shout;
      logic dout;
      logic seen0;
      logic [4:0] ones;
      logic [3:0] hold;
      logic signed [24:0] diff;
      logic signed [49:0] prod;
      logic [34:0] num;
      logic [24:0] rem;
      logic [34:0] quo;
      logic [5:0] dcnt;
   } aspc_state_s;

   localparam aspc_state_s RST_STATE = '{st: ST_IDLE, gain: GAIN_RESET, offs: OFFS_RESET,
                                        default: '0};

   aspc_state_s s, n;
   logic fifo_valid, fifo_pop, rise, fall, chop_mode, cont_mode, reset_hit, q_oor;
   logic [RAW_W-1:0] fifo_data;
   logic signed [24:0] raw_ext, raw_sc, offs_ext;
   logic signed [30:0] q_val;
   logic [15:0] sat_val, full16;
   logic [7:0] stat_byte;
   logic [24:0] r2;

   if (RAW_W < 20 || RAW_W > 24) begin : g_raw_check
      $error("aspc_top raw width must be 20 to 24 bits");
   end

   aspc_fifo #(.WIDTH(RAW_W), .DEPTH(FIFO_DEPTH)) u_raw_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(raw_valid),
      .in_ready(raw_ready),
      .in_data(raw_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // Register readback for the link
   function automatic logic [7:0] reg_rd(input aspc_state_s st, input logic [3:0] idx);
      logic [7:0] r;
      r = 8'h00;
      case (idx)
         IDX_CTRL: r = {2'b00, st.pend, st.ovf, st.mode};
         IDX_RES_FIRST: r = st.res[15:8];
         IDX_RES_SECOND: r = st.res[7:0];
         IDX_OFFS0: r = st.offs[23:16];
         IDX_OFFS1: r = st.offs[15:8];
         IDX_OFFS2: r = st.offs[7:0];
         IDX_GAIN_HI: r = st.gain[23:16];
         IDX_GAIN1: r = st.gain[15:8];
         IDX_GAIN2: r = st.gain[7:0];
         IDX_CHAN_SEL: r = {5'h00, st.chsel};
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // Register write; results and flags ignore writes
   function automatic aspc_state_s wr_byte(input aspc_state_s st, input logic [3:0] idx,
                                           input logic [7:0] d);
      aspc_state_s r;
      r = st;
      case (idx)
         IDX_CTRL: begin
            r.mode = d[3:0];
            if (d[3:0] != MODE_IDLE) begin
               r.pend = 1'b1;
            end
         end
         IDX_OFFS0: r.offs[23:16] = d;
         IDX_OFFS1: r.offs[15:8] = d;
         IDX_OFFS2: r.offs[7:0] = d;
         IDX_GAIN_HI: r.gain[23:16] = d;
         IDX_GAIN1: r.gain[15:8] = d;
         IDX_GAIN2: r.gain[7:0] = d;
         IDX_CHAN_SEL: r.chsel = d[2:0];
         default: r = st;
      endcase
      return r;
   endfunction

   // Link edges found from the synchronised clock
   assign rise = s.sck_s2 & ~s.sck_d;
   assign fall = ~s.sck_s2 & s.sck_d;
   assign full16 = {s.shin[14:0], s.din_s2};
   assign stat_byte = {6'h00, s.pend, s.ovf};

   // Arithmetic helpers for the correction path
   assign chop_mode = (s.mode == MODE_SINGLE_CHOP) || (s.mode == MODE_CONT_CHOP) ||
                      (s.mode == MODE_GAIN_INT) || (s.mode == MODE_GAIN_SYS);
   assign cont_mode = (s.mode == MODE_CONT) || (s.mode == MODE_CONT_CHOP);
   assign raw_ext = 25'(signed'(fifo_data));
   // Chopped samples sum two half conversions, so they arrive at double scale
   assign raw_sc = chop_mode ? (raw_ext >>> 1) : raw_ext;
   assign offs_ext = {s.offs[23], s.offs};
   assign q_val = s.prod[49:SCALE_SHIFT];
   assign q_oor = (q_val < RESULT_MIN) || (q_val > OVF_LIMIT_HI);
   assign sat_val = q_oor ? (q_val[30] ? 16'h8000 : 16'h7FFF) :
                    ((q_val > RESULT_MAX) ? 16'h7FFF : q_val[15:0]);
   assign r2 = {s.rem[23:0], s.num[34]};

   // Engine and link next state
   always_comb begin
      n = s;
      fifo_pop = 1'b0;
      reset_hit = 1'b0;
      n.sck_s1 = link_clk;
      n.sck_s2 = s.sck_s1;
      n.sck_d = s.sck_s2;
      n.din_s1 = link_din;
      n.din_s2 = s.din_s1;
      case (s.st)
         ST_IDLE: begin
            fifo_pop = fifo_valid;
            if (fifo_valid) begin
               case (s.mode)
                  MODE_SINGLE, MODE_CONT, MODE_SINGLE_CHOP, MODE_CONT_CHOP: begin
                     // Unread result is dropped; ready rises until the new one lands
                     n.pend = 1'b1;
                     n.rd_first = 1'b0;
                     n.rd_second = 1'b0;
                     n.diff = chop_mode ? raw_sc : 25'(raw_sc - offs_ext);
                     n.st = ST_MUL;
                  end
                  MODE_OFFS_INT, MODE_OFFS_AMP, MODE_OFFS_SYS: begin
                     n.offs = raw_sc[23:0];
                     n.pend = 1'b0;
                     n.mode = MODE_IDLE;
                  end
                  MODE_GAIN_INT, MODE_GAIN_SYS: begin
                     // Divisor floor of one avoids a divide by zero on a dead input
                     n.diff = (raw_sc > 0) ? raw_sc : 25'h0000001;
                     n.num = GAIN_NUMERATOR;
                     n.rem = 25'h0000000;
                     n.quo = 35'h000000000;
                     n.dcnt = DIV_STEPS;
                     n.st = ST_DIV;
                  end
                  default: n.st = ST_IDLE;
               endcase
            end
         end
         ST_MUL: begin
            n.prod = 50'(s.diff * signed'({1'b0, s.gain}));
            n.st = ST_STORE;
         end
         ST_STORE: begin
            n.ovf = q_oor;
            n.res = sat_val;
            n.pend = 1'b0;
            if (s.mode == MODE_SINGLE || s.mode == MODE_SINGLE_CHOP) begin
               n.mode = MODE_IDLE;
            end
            n.st = ST_IDLE;
         end
         ST_DIV: begin
            // One quotient bit per cycle, restoring division
            n.num = {s.num[33:0], 1'b0};
            if (r2 >= unsigned'(s.diff)) begin
               n.rem = 25'(r2 - unsigned'(s.diff));
               n.quo = {s.quo[33:0], 1'b1};
            end else begin
               n.rem = r2;
               n.quo = {s.quo[33:0], 1'b0};
            end
            n.dcnt = s.dcnt - 6'h01;
            if (s.dcnt == 6'h01) begin
               n.st = ST_GSTORE;
            end
         end
         ST_GSTORE: begin
            n.gain = (|s.quo[34:24]) ? 24'hFFFFFF : s.quo[23:0];
            n.pend = 1'b0;
            n.mode = MODE_IDLE;
            n.st = ST_IDLE;
         end
         default: n.st = ST_IDLE;
      endcase

      // Link is ignored while the start-up hold runs down
      if (s.hold != 4'h0) begin
         n.hold = s.hold - 4'h1;
      end else begin
         // No chip select: the first clock edge opens a frame
         if ((rise || fall) && !s.act) begin
            n.act = 1'b1;
            n.cnt = 5'h00;
            n.shout = {stat_byte, 8'h00};
         end
         if (rise) begin
            n.dout = s.act ? s.shout[15] : stat_byte[7];
            n.shout = s.act ? {s.shout[14:0], 1'b0} : {stat_byte[6:0], 9'h000};
         end
         if (fall) begin
            n.shin = full16;
            n.cnt = s.cnt + 5'h01;
            if (!s.din_s2) begin
               n.seen0 = 1'b1;
               n.ones = 5'h00;
            end else if (s.seen0 && s.ones != RESET_ONES) begin
               n.ones = s.ones + 5'h01;
            end
            reset_hit = s.seen0 && s.din_s2 && (s.ones == RESET_ONES - 5'h01);
            if (!s.in_data && s.cnt == CMD_LAST_BIT) begin
               n.cmd = full16[7:0];
               n.len16 = full16[CMD_LEN_BIT];
               n.in_data = 1'b1;
               n.cnt = 5'h00;
               n.shout = {reg_rd(s, full16[CMD_IDX_HI:CMD_IDX_LO]),
                          full16[CMD_LEN_BIT] ?
                          reg_rd(s, 4'(full16[CMD_IDX_HI:CMD_IDX_LO] + 4'h1)) : 8'h00};
            end else if (s.in_data &&
                         s.cnt == (s.len16 ? DATA16_LAST_BIT : DATA8_LAST_BIT)) begin
               if (!s.cmd[CMD_RW_BIT]) begin
                  if (s.len16) begin
                     n = wr_byte(n, s.cmd[CMD_IDX_HI:CMD_IDX_LO], full16[15:8]);
                     n = wr_byte(n, 4'(s.cmd[CMD_IDX_HI:CMD_IDX_LO] + 4'h1), full16[7:0]);
                  end else begin
                     n = wr_byte(n, s.cmd[CMD_IDX_HI:CMD_IDX_LO], full16[7:0]);
                  end
               end else begin
                  if (s.cmd[CMD_IDX_HI:CMD_IDX_LO] == IDX_RES_FIRST) begin
                     n.rd_first = 1'b1;
                     n.rd_second = n.rd_second | s.len16;
                  end
                  if (s.cmd[CMD_IDX_HI:CMD_IDX_LO] == IDX_RES_SECOND) begin
                     n.rd_second = 1'b1;
                  end
                  if (n.rd_first && n.rd_second && cont_mode && s.st != ST_STORE) begin
                     n.pend = 1'b1;
                     n.rd_first = 1'b0;
                     n.rd_second = 1'b0;
                  end
               end
               // Back to waiting for a command byte
               n.in_data = 1'b0;
               n.act = 1'b0;
               n.cnt = 5'h00;
            end
         end
      end
      // Outside a frame the pin shows the pending flag
      if (!n.act) begin
         n.dout = s.pend;
      end
      // In-band reset returns all state but the synchronisers and the start-up hold; the raw FIFO is not cleared
      if (reset_hit) begin
         n = RST_STATE;
         n.hold = STARTUP_CYC;
         n.sck_s1 = link_clk;
         n.sck_s2 = s.sck_s1;
         n.sck_d = s.sck_s2;
         n.din_s1 = link_din;
         n.din_s2 = s.din_s1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= RST_STATE;
      end else begin
         s <= n;
      end
   end

   // Converter-side controls follow the current mode and the channel select register
   assign link_dout = s.dout;
   assign conv_mode = s.mode;
   assign input_channel_select = s.chsel;
   assign first_stage_enable = !((s.mode == MODE_GAIN_INT) || (s.mode == MODE_OFFS_INT));
   assign second_stage_unity = (s.mode == MODE_GAIN_INT) || (s.mode == MODE_OFFS_INT);
   assign ref_to_input = (s.mode == MODE_GAIN_INT);
   assign gnd_to_input = (s.mode == MODE_GAIN_INT) || (s.mode == MODE_OFFS_INT);
   assign conversion_pending_flag = s.pend;
   assign result_overflow_flag = s.ovf;

   // Checks on the correction path and the link
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_OVF_FLAG: assert property ((s.st == ST_STORE) |=> (s.ovf == $past(q_oor)))
      else $error("overflow flag does not match corrected value");
   AST_SAT_HI: assert property ((s.st == ST_STORE && q_oor && !q_val[30]) |=>
      (s.res == 16'h7FFF))
      else $error("positive overflow not saturated");
   AST_SAT_LO: assert property ((s.st == ST_STORE && q_oor && q_val[30]) |=>
      (s.res == 16'h8000))
      else $error("negative overflow not saturated");
   AST_SCALE: assert property ((s.st == ST_STORE && !q_oor && q_val <= RESULT_MAX) |=>
      (s.res == $past(s.prod[34:19])))
      else $error("stored result not product scaled by 0x80000");
   AST_OFFS_SUB: assert property ((fifo_pop && !chop_mode &&
      (s.mode == MODE_SINGLE || s.mode == MODE_CONT)) |=>
      (s.diff == 25'($past(raw_sc) - $past(offs_ext))) ##1 (s.st == ST_STORE))
      else $error("offset not subtracted before gain");
   AST_CHOP_NOOFF: assert property ((fifo_pop &&
      (s.mode == MODE_SINGLE_CHOP || s.mode == MODE_CONT_CHOP)) |=>
      (s.diff == $past(raw_sc)))
      else $error("chopping mode used the offset");
   AST_IDLE_RDY: assert property ((!s.act && !reset_hit ##1 !s.act) |->
      (link_dout == $past(s.pend)))
      else $error("idle data out does not show pending flag");
   // Host clock idles low, so a frame opens on a rise: bit 7 is on the pin already
   AST_STATUS: assert property ((!s.act && rise && s.hold == 4'h0 && !reset_hit) |=>
      ({link_dout, s.shout[15:9]} == {6'h00, $past(s.pend), $past(s.ovf)}))
      else $error("status byte snapshot wrong");
   AST_RESET: assert property (reset_hit |=>
      (s.mode == MODE_IDLE && s.hold == STARTUP_CYC && !s.act))
      else $error("reset pattern did not reset the block");
   AST_HOLD: assert property ((s.hold != 4'h0 && fall) |=> (s.cnt == $past(s.cnt)))
      else $error("link bit taken during start-up hold");
   AST_DIV_LEN: assert property ($rose(s.st == ST_DIV) |-> ##35 (s.st == ST_GSTORE))
      else $error("gain calculation length wrong");
   AST_GAIN_DONE: assert property ((s.st == ST_GSTORE) |=>
      (s.mode == MODE_IDLE && !s.pend && s.st == ST_IDLE))
      else $error("gain calibration did not finish properly");
   AST_INT_CAL: assert property ((s.mode == MODE_GAIN_INT) |->
      (!first_stage_enable && second_stage_unity && ref_to_input && gnd_to_input))
      else $error("internal gain calibration input setup wrong");

   CV_SINGLE: cover property ((s.st == ST_STORE && s.mode == MODE_SINGLE) ##1 !s.pend);
   CV_DISCARD: cover property (fifo_pop && cont_mode && !s.pend);
   CV_GAIN: cover property (s.st == ST_GSTORE);
   CV_RESET: cover property (reset_hit);
endmodule // aspc_top

// ### shared/aspc_pkg.sv
package aspc_pkg;
   // Register indices carried in the command byte
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_RES_FIRST = 4'h1;
   localparam logic [3:0] IDX_RES_SECOND = 4'h2;
   localparam logic [3:0] IDX_OFFS0 = 4'h3;
   localparam logic [3:0] IDX_OFFS1 = 4'h4;
   localparam logic [3:0] IDX_OFFS2 = 4'h5;
   localparam logic [3:0] IDX_GAIN_HI = 4'h6;
   localparam logic [3:0] IDX_GAIN1 = 4'h7;
   localparam logic [3:0] IDX_GAIN2 = 4'h8;
   localparam logic [3:0] IDX_CHAN_SEL = 4'h9;
   // Operating modes held in the control register
   localparam logic [3:0] MODE_IDLE = 4'h0;
   localparam logic [3:0] MODE_SINGLE = 4'h2;
   localparam logic [3:0] MODE_CONT = 4'h3;
   localparam logic [3:0] MODE_SINGLE_CHOP = 4'h4;
   localparam logic [3:0] MODE_CONT_CHOP = 4'h5;
   localparam logic [3:0] MODE_OFFS_INT = 4'h8;
   localparam logic [3:0] MODE_GAIN_INT = 4'h9;
   localparam logic [3:0] MODE_OFFS_AMP = 4'hA;
   localparam logic [3:0] MODE_OFFS_SYS = 4'hC;
   localparam logic [3:0] MODE_GAIN_SYS = 4'hD;
   // Command byte fields
   localparam int CMD_IDX_HI = 7;
   localparam int CMD_IDX_LO = 4;
   localparam int CMD_RW_BIT = 3;
   localparam int CMD_LEN_BIT = 2;
   // Link framing and in-band reset
   localparam logic [4:0] CMD_LAST_BIT = 5'h07;
   localparam logic [4:0] DATA8_LAST_BIT = 5'h07;
   localparam logic [4:0] DATA16_LAST_BIT = 5'h0F;
   localparam logic [4:0] RESET_ONES = 5'h17;
   // Start-up hold after an in-band reset
   localparam int STARTUP_NS = 400;
   localparam int CLOCK_PERIOD_NS = 40;
   localparam int STARTUP_CYC_I = (STARTUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam logic [3:0] STARTUP_CYC = 4'(STARTUP_CYC_I);
   // Correction arithmetic: filter full scale 262144, divide by 0x80000
   localparam int SCALE_SHIFT = 19;
   localparam logic signed [30:0] RESULT_MIN = -31'sd32768;
   localparam logic signed [30:0] RESULT_MAX = 31'sd32767;
   localparam logic signed [30:0] OVF_LIMIT_HI = 31'sd32768;
   // Gain calibration target: 32768 * 0x80000 = 2^34
   localparam logic [34:0] GAIN_NUMERATOR = 35'h400000000;
   localparam logic [5:0] DIV_STEPS = 6'h23;
   // Values after reset
   localparam logic [23:0] GAIN_RESET = 24'h010000;
   localparam logic [23:0] OFFS_RESET = 24'h000000;
   // Correction engine states
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_MUL = 5'b00010,
      ST_STORE = 5'b00100,
      ST_DIV = 5'b01000,
      ST_GSTORE = 5'b10000
   } aspc_core_e;
endpackage

// ### test/aspc_host_model.sv
`timescale 1ns/10ps
// Host controller driving the three-wire serial link
module aspc_host_model (
   input wire logic clock,
   output logic link_clk,
   output logic link_din,
   input wire logic link_dout
);
   // Link clock idles low; outside frames it moves only for the reset stray pulse
   initial begin
      link_clk = 1'b0;
      link_din = 1'b1;
   end
   // Four system clocks per half gives the 320 ns link period
   task automatic half();
      repeat (4) @(negedge clock);
   endtask
   // Shift n bits out MSB first; data-out taken mid low phase, where it stands
   task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
      rx = 24'h000000;
      for (int i = 0; i < n; i++) begin
         // Data in moves mid low phase, clear of the sampling fall
         link_din = tx[23-i];
         repeat (2) @(negedge clock);
         link_clk = 1'b1;
         half();
         link_clk = 1'b0;
         repeat (2) @(negedge clock);
         rx = {rx[22:0], link_dout};
      end
      // Released line must not keep showing the last bit
      link_din = ~link_din;
      // Ready level reaches data out a clock after the frame closes
      half();
   endtask
   // In-band reset pattern, then the start-up hold
   task automatic reset_seq();
      logic [23:0] rx;
      xfer(24'h7FFFFF, 24, rx);
      // Stray pulse inside the start-up hold must not open a frame
      link_clk = 1'b1;
      repeat (2) @(negedge clock);
      link_clk = 1'b0;
      repeat (10) @(negedge clock);
   endtask
endmodule // aspc_host_model

// ### test/aspc_tb_top.sv
`timescale 1ns/10ps
module aspc_tb_top;
   import aspc_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic raw_valid = 1'b0;
   logic [23:0] raw_data = 24'h000000;
   logic link_clk, link_din, link_dout, raw_ready;
   logic [3:0] conv_mode;
   logic [2:0] input_channel_select;
   logic first_stage_enable, second_stage_unity, ref_to_input, gnd_to_input;
   logic conversion_pending_flag, result_overflow_flag;
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   // Saturation table: raw value, expected result, expected overflow
   logic [23:0] raws [6] = '{24'h013880, 24'h04E200, 24'hFB1E00, 24'h040000, 24'hFC0000,
      24'hFBFFF8};
   logic [15:0] ress [6] = '{16'h2710, 16'h7FFF, 16'h8000, 16'h7FFF, 16'h8000, 16'h8000};
   logic ovs [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

   aspc_top u_aspc_top (.clock(clock), .rst_n(rst_n), .link_clk(link_clk), .link_din(link_din),
      .link_dout(link_dout), .raw_valid(raw_valid), .raw_ready(raw_ready), .raw_data(raw_data),
      .conv_mode(conv_mode), .input_channel_select(input_channel_select),
      .first_stage_enable(first_stage_enable), .second_stage_unity(second_stage_unity),
      .ref_to_input(ref_to_input), .gnd_to_input(gnd_to_input),
      .conversion_pending_flag(conversion_pending_flag),
      .result_overflow_flag(result_overflow_flag));
   aspc_host_model u_aspc_host_model (.clock(clock), .link_clk(link_clk), .link_din(link_din),
      .link_dout(link_dout));

   always #20 clock = ~clock;
   // Hang guard, well above the few thousand cycles the tests need
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Read: status byte then 8 or 16 data bits
   task automatic reg_rd(input logic [3:0] idx, input logic len16, output logic [23:0] rx);
      u_aspc_host_model.xfer({idx, 1'b1, len16, 2'b00, 16'h0000}, len16 ? 24 : 16, rx);
   endtask
   task automatic reg_wr(input logic [3:0] idx, input logic len16, input logic [15:0] d);
      logic [23:0] rx;
      u_aspc_host_model.xfer({idx, 1'b0, len16, 2'b00, len16 ? d : {d[7:0], 8'h00}},
         len16 ? 24 : 16, rx);
   endtask
   // Hand one raw sample over, then wait for the result to land
   task automatic conv(input logic [23:0] raw);
      int k;
      raw_valid = 1'b1;
      raw_data = raw;
      k = 0;
      while (raw_ready !== 1'b1 && k < 100) begin
         @(negedge clock);
         k++;
      end
      @(negedge clock);
      raw_valid = 1'b0;
      repeat (5) @(negedge clock);
      while (conversion_pending_flag !== 1'b0 && k < 200) begin
         @(negedge clock);
         k++;
      end
      // Data out follows the flag one clock late
      @(negedge clock);
   endtask

   initial begin
      logic [23:0] rx;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      reg_rd(IDX_CTRL, 1'b0, rx); cmp(rx, 24'h000000);
      reg_rd(IDX_GAIN_HI, 1'b1, rx); cmp(rx, 24'h000100);
      // Single conversions around both saturation limits
      for (int i = 0; i < 6; i++) begin
         reg_wr(IDX_CTRL, 1'b0, 16'h0002);
         cmp({23'h0, link_dout}, 24'h000001);
         conv(raws[i]);
         cmp({20'h0, conv_mode}, 24'h000000);
         cmp({23'h0, link_dout}, 24'h000000);
         reg_rd(IDX_RES_FIRST, 1'b1, rx); cmp(rx, {7'h00, ovs[i], ress[i]});
      end
      // Offset 2048 applies in plain mode, not in chopping mode
      reg_wr(IDX_OFFS1, 1'b1, 16'h0800);
      reg_wr(IDX_CTRL, 1'b0, 16'h0002);
      conv(24'h013880);
      reg_rd(IDX_RES_FIRST, 1'b1, rx); cmp(rx, 24'h002610);
      reg_wr(IDX_CTRL, 1'b0, 16'h0004);
      conv(24'h027100);
      reg_rd(IDX_RES_FIRST, 1'b1, rx); cmp(rx, 24'h002710);
      // Continuous: ready falls on store, rises on read, unread data overwritten
      reg_wr(IDX_CTRL, 1'b0, 16'h0003);
      conv(24'h013880);
      cmp({23'h0, link_dout}, 24'h000000);
      reg_rd(IDX_RES_FIRST, 1'b1, rx); cmp(rx, 24'h002610);
      cmp({23'h0, link_dout}, 24'h000001);
      conv(24'h027100);
      conv(24'h03A980);
      reg_wr(IDX_CTRL, 1'b0, 16'h0000);
      reg_wr(IDX_RES_FIRST, 1'b0, 16'h00AA);
      reg_rd(IDX_RES_FIRST, 1'b1, rx); cmp(rx, 24'h007430);
      // Gain calibration: internal then system on channel 3
      reg_wr(IDX_CHAN_SEL, 1'b0, 16'h0003);
      cmp({21'h0, input_channel_select}, 24'h000003);
      reg_wr(IDX_CTRL, 1'b0, 16'h0009);
      cmp({20'h0, first_stage_enable, second_stage_unity, ref_to_input, gnd_to_input},
         24'h000007);
      conv(24'h040000);
      cmp({20'h0, conv_mode}, 24'h000000);
      reg_rd(IDX_GAIN_HI, 1'b1, rx); cmp(rx, 24'h000200);
      reg_wr(IDX_CTRL, 1'b0, 16'h000D);
      conv(24'h080000);
      reg_rd(IDX_GAIN_HI, 1'b1, rx); cmp(rx, 24'h000100);
      // In-band reset brings the gain back
      reg_wr(IDX_GAIN_HI, 1'b1, 16'h0300);
      u_aspc_host_model.reset_seq();
      reg_rd(IDX_GAIN_HI, 1'b1, rx); cmp(rx, 24'h000100);
      conclude();
   end
endmodule // aspc_tb_top
